/* File: activity_detect.sv */
// activity_detect: flags level changes on microcontroller activity lines
// assumes lines are synchronous to clk_i
`timescale 1ns/1ps
module activity_detect #(
  parameter int N = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [N-1:0] lines_i,
  activity_if.src act
);
  import glue_pkg::*;

  typedef struct packed {
    logic primed;
    logic [N-1:0] prev;
    logic [N-1:0] seen;
  } act_state_t;

  act_state_t st;
  act_state_t next_st;
  logic [N-1:0] edge_hit;

  // -----------------------------
  // per-line change detect
  // -----------------------------
  for (genvar g = 0; g < N; g++) begin : g_line
    assign edge_hit[g] = st.primed & (lines_i[g] ^ st.prev[g]);
  end

  always_comb begin
    next_st = st;
    next_st.primed = 1'b1;
    next_st.prev = lines_i;
    next_st.seen = edge_hit;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign act.seen = st.seen;

endmodule : activity_detect

/* File: activity_if.sv */
// activity_if: carries per-line activity pulses between glue modules
// assumes both ends run on the board clock
`timescale 1ns/1ps
interface activity_if #(parameter int N = 4);
  logic [N-1:0] seen;
  modport src (output seen);
  modport dst (input seen);
endinterface : activity_if

/* File: glue_pkg.sv */
// glue_pkg: constants and state types of the segment glue logic
// assumes a single 200 MHz board clock
package glue_pkg;

  // -----------------------------
  // clock and timing
  // -----------------------------
  localparam int CLK_KHZ = 200000;
  localparam int KICK_TIME_MS = 1600;
  localparam int KICK_CYCLES_DFLT = KICK_TIME_MS * CLK_KHZ;
  localparam int CNT_W = 32;

  // -----------------------------
  // widths and reset values
  // -----------------------------
  localparam int MUX_CH = 8;
  localparam int MUX_W = $clog2(MUX_CH);
  localparam int ADDR_W = 8;
  localparam int ACT_N = 4;
  localparam int ACT_KEEPALIVE = 0;
  localparam int ACT_BUS_ENA = 1;
  localparam int ACT_MD_RX = 2;
  localparam int ACT_MD_TX = 3;
  localparam logic RST_MD_EN = 1'b1;
  localparam logic RST_FP_EN = 1'b0;
  localparam logic RST_KICK = 1'b0;
  localparam logic RST_SUPPLY = 1'b0;
  localparam logic RST_RF = 1'b0;
  localparam logic [MUX_W-1:0] RST_MUX = 3'h0;
  localparam logic [MUX_W-1:0] MUX_INC = 3'h1;

  // -----------------------------
  // state of the top module
  // -----------------------------
  typedef struct packed {
    logic [CNT_W-1:0] tmr;
    logic alive;
    logic kick;
    logic supply;
    logic rf;
    logic md_en;
    logic fp_en;
    logic [MUX_W-1:0] mux;
    logic match;
  } glue_state_t;

endpackage : glue_pkg

/* File: segment_glue.sv */
// segment_glue: watchdog service, supply gating, rf switch, serial select
// assumes one board clock and inputs synchronous to it
`timescale 1ns/1ps

// Behaviour
// - on stall, supervisor nmi low is passed on to the microcontroller
// - normally reset and nmi lines to the microcontroller stay high
// - keepalive toggle, bus enable or multidrop activity all mean alive
// - while alive, kick output toggles once every 1.6 s
// - with routing jumper fitted this logic sources the kick toggles
// - microcontroller request drives the drain supply enable output
// - supply enable granted only when standby and interlocks allow it
// - any unsafe condition forces the supply enable output low
// - rf switch high in transmit state, else terminated
// - multidrop driver enabled after reset
// - front-panel driver disabled after reset
// - front select low enables front port and disables multidrop port
// - both ports carry the mcu transmit data; mcu receive comes only from the enabled port
// - only frames addressed to the node address switch are accepted
// - analog mux steps through 8 drain-current channels on request
module segment_glue #(
  parameter int KICK_CYCLES = glue_pkg::KICK_CYCLES_DFLT
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic mcu_keepalive_pin_i,
  input wire logic mcu_bus_driver_enable_i,
  input wire logic multidrop_rx_i,
  input wire logic mcu_tx_i,
  input wire logic front_rx_i,
  input wire logic watchdog_route_jumper_i,
  input wire logic supervisor_nmi_n_i,
  input wire logic supervisor_reset_n_i,
  input wire logic mcu_supply_request_i,
  input wire logic standby_i,
  input wire logic gate_interlock_ok_i,
  input wire logic unsafe_detect_i,
  input wire logic transmit_state_i,
  input wire logic front_port_select_n_i,
  input wire logic [glue_pkg::ADDR_W-1:0] node_address_switch_i,
  input wire logic [glue_pkg::ADDR_W-1:0] frame_addr_i,
  input wire logic frame_addr_valid_i,
  input wire logic mux_step_i,
  input wire logic mux_load_i,
  input wire logic [glue_pkg::MUX_W-1:0] mux_value_i,
  output logic supervisor_kick_o,
  output logic supervisor_kick_oe_o,
  output logic nonmaskable_irq_n_o,
  output logic mcu_reset_n_o,
  output logic drain_supply_enable_out_o,
  output logic rf_path_switch_o,
  output logic multidrop_driver_enable_o,
  output logic front_port_driver_enable_o,
  output logic multidrop_tx_o,
  output logic front_tx_o,
  output logic mcu_rx_o,
  output logic addr_match_o,
  output logic [glue_pkg::MUX_W-1:0] mux_select_o
);
  import glue_pkg::*;

  localparam logic [CNT_W-1:0] KICK_LAST = CNT_W'(KICK_CYCLES - 1);

  logic rst_meta;
  logic rst_n;
  glue_state_t st;
  glue_state_t next_st;
  logic expire;
  logic any_seen;
  logic safe;

  activity_if #(.N(ACT_N)) act ();

  // -----------------------------
  // reset release
  // -----------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // -----------------------------
  // activity detection
  // -----------------------------
  activity_detect #(.N(ACT_N)) u_act (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .lines_i({mcu_tx_i, multidrop_rx_i, mcu_bus_driver_enable_i, mcu_keepalive_pin_i}),
    .act(act.src)
  );

  // -----------------------------
  // next state
  // -----------------------------
  assign expire = (st.tmr == KICK_LAST);
  assign any_seen = |act.seen;
  assign safe = !standby_i && gate_interlock_ok_i && !unsafe_detect_i;

  always_comb begin
    next_st = st;
    // kick interval counter
    if (expire) begin
      next_st.tmr = '0;
    end else begin
      next_st.tmr = st.tmr + CNT_W'(1);
    end
    // alive flag, new activity wins over the clear
    if (any_seen) begin
      next_st.alive = 1'b1;
    end else if (expire) begin
      next_st.alive = 1'b0;
    end
    // kick toggle once per interval while alive
    if (expire && st.alive && watchdog_route_jumper_i) begin
      next_st.kick = !st.kick;
    end
    // drain supply gating
    next_st.supply = mcu_supply_request_i && safe;
    // rf input switch
    next_st.rf = transmit_state_i;
    // serial port choice
    next_st.md_en = front_port_select_n_i;
    next_st.fp_en = !front_port_select_n_i;
    // analog mux channel
    if (mux_load_i) begin
      next_st.mux = mux_value_i;
    end else if (mux_step_i) begin
      next_st.mux = st.mux + MUX_INC;
    end
    // node address filter
    next_st.match = frame_addr_valid_i && (frame_addr_i == node_address_switch_i);
  end

  // -----------------------------
  // state register
  // -----------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st.tmr <= '0;
      st.alive <= 1'b0;
      st.kick <= RST_KICK;
      st.supply <= RST_SUPPLY;
      st.rf <= RST_RF;
      st.md_en <= RST_MD_EN;
      st.fp_en <= RST_FP_EN;
      st.mux <= RST_MUX;
      st.match <= 1'b0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // -----------------------------
  // outputs
  // -----------------------------
  assign supervisor_kick_o = st.kick;
  assign supervisor_kick_oe_o = watchdog_route_jumper_i;
  assign nonmaskable_irq_n_o = supervisor_nmi_n_i;
  assign mcu_reset_n_o = supervisor_reset_n_i;
  assign drain_supply_enable_out_o = st.supply;
  assign rf_path_switch_o = st.rf;
  assign multidrop_driver_enable_o = st.md_en;
  assign front_port_driver_enable_o = st.fp_en;
  assign multidrop_tx_o = mcu_tx_i;
  assign front_tx_o = mcu_tx_i;
  assign mcu_rx_o = st.fp_en ? front_rx_i : multidrop_rx_i;
  assign addr_match_o = st.match;
  assign mux_select_o = st.mux;

  // -----------------------------
  // assertions
  // -----------------------------
  property p_kick_on_expiry;
    @(posedge clk_i) disable iff (!rst_n)
      (ce_i && !(expire && st.alive && watchdog_route_jumper_i)) |=> $stable(supervisor_kick_o);
  endproperty
  a_kick_on_expiry: assert property (p_kick_on_expiry)
    else $error("kick changed outside an interval end");

  property p_kick_toggles;
    @(posedge clk_i) disable iff (!rst_n)
      (ce_i && expire && st.alive && watchdog_route_jumper_i) |=> (supervisor_kick_o != $past(supervisor_kick_o));
  endproperty
  a_kick_toggles: assert property (p_kick_toggles)
    else $error("kick missed a toggle while alive");

  property p_alive_set;
    @(posedge clk_i) disable iff (!rst_n)
      (ce_i && any_seen) |=> st.alive;
  endproperty
  a_alive_set: assert property (p_alive_set)
    else $error("activity did not mark alive");

  property p_tmr_bound;
    @(posedge clk_i) disable iff (!rst_n)
      st.tmr <= KICK_LAST;
  endproperty
  a_tmr_bound: assert property (p_tmr_bound)
    else $error("interval counter beyond its count");

  property p_nmi_pass;
    @(posedge clk_i) disable iff (!rst_n)
      (nonmaskable_irq_n_o == supervisor_nmi_n_i) && (mcu_reset_n_o == supervisor_reset_n_i);
  endproperty
  a_nmi_pass: assert property (p_nmi_pass)
    else $error("supervisor lines not passed on");

  property p_supply_unsafe;
    @(posedge clk_i) disable iff (!rst_n)
      (ce_i && (standby_i || !gate_interlock_ok_i || unsafe_detect_i)) |=> !drain_supply_enable_out_o;
  endproperty
  a_supply_unsafe: assert property (p_supply_unsafe)
    else $error("supply enabled while unsafe");

  property p_supply_grant;
    @(posedge clk_i) disable iff (!rst_n)
      (ce_i && mcu_supply_request_i && safe) |=> drain_supply_enable_out_o;
  endproperty
  a_supply_grant: assert property (p_supply_grant)
    else $error("safe request not granted");

  property p_rf_follow;
    @(posedge clk_i) disable iff (!rst_n)
      ce_i |=> (rf_path_switch_o == $past(transmit_state_i));
  endproperty
  a_rf_follow: assert property (p_rf_follow)
    else $error("rf switch does not follow transmit state");

  property p_port_select;
    @(posedge clk_i) disable iff (!rst_n)
      (ce_i && !front_port_select_n_i) |=> (front_port_driver_enable_o && !multidrop_driver_enable_o);
  endproperty
  a_port_select: assert property (p_port_select)
    else $error("front select did not swap ports");

  property p_port_excl;
    @(posedge clk_i) disable iff (!rst_n)
      multidrop_driver_enable_o != front_port_driver_enable_o;
  endproperty
  a_port_excl: assert property (p_port_excl)
    else $error("serial ports not exclusive");

  property p_rx_path;
    @(posedge clk_i) disable iff (!rst_n)
      mcu_rx_o == (front_port_driver_enable_o ? front_rx_i : multidrop_rx_i);
  endproperty
  a_rx_path: assert property (p_rx_path)
    else $error("receive path from wrong port");

  property p_addr_match;
    @(posedge clk_i) disable iff (!rst_n)
      (ce_i && frame_addr_valid_i && (frame_addr_i != node_address_switch_i)) |=> !addr_match_o;
  endproperty
  a_addr_match: assert property (p_addr_match)
    else $error("foreign address accepted");

  property p_mux_step;
    @(posedge clk_i) disable iff (!rst_n)
      (ce_i && mux_step_i && !mux_load_i) |=> (mux_select_o == $past(mux_select_o) + MUX_INC);
  endproperty
  a_mux_step: assert property (p_mux_step)
    else $error("mux did not step");

  property p_freeze;
    @(posedge clk_i) disable iff (!rst_n)
      !ce_i |=> ($stable(mux_select_o) && $stable(supervisor_kick_o) && $stable(drain_supply_enable_out_o));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved with clock enable low");

  property p_addr_own;
    @(posedge clk_i) disable iff (!rst_n)
      (ce_i && frame_addr_valid_i && (frame_addr_i == node_address_switch_i)) |=> addr_match_o;
  endproperty
  a_addr_own: assert property (p_addr_own)
    else $error("own address not matched");

  property p_mux_load;
    @(posedge clk_i) disable iff (!rst_n)
      (ce_i && mux_load_i) |=> (mux_select_o == $past(mux_value_i));
  endproperty
  a_mux_load: assert property (p_mux_load)
    else $error("mux did not load requested channel");

  property p_alive_clear;
    @(posedge clk_i) disable iff (!rst_n)
      (ce_i && expire && !any_seen) |=> !st.alive;
  endproperty
  a_alive_clear: assert property (p_alive_clear)
    else $error("alive kept over a quiet interval");

  property p_port_default;
    @(posedge clk_i) disable iff (!rst_n)
      (ce_i && front_port_select_n_i) |=> (multidrop_driver_enable_o && !front_port_driver_enable_o);
  endproperty
  a_port_default: assert property (p_port_default)
    else $error("multidrop port not enabled");

  c_kick: cover property (@(posedge clk_i) disable iff (!rst_n) $changed(supervisor_kick_o));
  c_front: cover property (@(posedge clk_i) disable iff (!rst_n) $rose(front_port_driver_enable_o));
  c_supply: cover property (@(posedge clk_i) disable iff (!rst_n) $fell(drain_supply_enable_out_o));
  c_match: cover property (@(posedge clk_i) disable iff (!rst_n) addr_match_o);
  c_mux_wrap: cover property (@(posedge clk_i) disable iff (!rst_n) $changed(mux_select_o) && (mux_select_o == RST_MUX));

endmodule : segment_glue

/* File: segment_glue_tb_top.sv */
// segment_glue_tb_top: self-checking bench for the segment glue logic
// assumes glue_pkg, activity_if and the design files are compiled first
`timescale 1ns/1ps
module segment_glue_tb_top;
  import glue_pkg::*;
  // ---------------------------
  // stimulus and wiring
  // ---------------------------
  localparam int KC = 64;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1, keep = 1'b0, bus_en = 1'b0, md_rx = 1'b0, tx = 1'b0, fr_rx = 1'b0, jmp = 1'b1;
  logic req = 1'b0, stby = 1'b0, gate_ok = 1'b1, unsafe = 1'b0, xmit = 1'b0, sel_n = 1'b1;
  logic fvalid = 1'b0, mstep = 1'b0, mload = 1'b0;
  logic [ADDR_W-1:0] node = 8'h5a, faddr = 8'h00;
  logic [MUX_W-1:0] mval = 3'h0;
  logic [MUX_W-1:0] mux;
  logic kick, kick_oe, sup_nmi_n, sup_rst_n, nmi_n, rst_n, supply, rf, md_en, fp_en, md_tx, fp_tx, mcu_rx, match;
  int fails = 0;
  int compares = 0;
  int gap = 0;
  always #2.5 clk = ~clk;
  segment_glue #(.KICK_CYCLES(KC)) segment_glue_inst (
    .clk_i(clk), .nrst_i(nrst), .ce_i(ce), .mcu_keepalive_pin_i(keep), .mcu_bus_driver_enable_i(bus_en),
    .multidrop_rx_i(md_rx), .mcu_tx_i(tx), .front_rx_i(fr_rx), .watchdog_route_jumper_i(jmp),
    .supervisor_nmi_n_i(sup_nmi_n), .supervisor_reset_n_i(sup_rst_n), .mcu_supply_request_i(req),
    .standby_i(stby), .gate_interlock_ok_i(gate_ok), .unsafe_detect_i(unsafe), .transmit_state_i(xmit),
    .front_port_select_n_i(sel_n), .node_address_switch_i(node), .frame_addr_i(faddr),
    .frame_addr_valid_i(fvalid), .mux_step_i(mstep), .mux_load_i(mload), .mux_value_i(mval),
    .supervisor_kick_o(kick), .supervisor_kick_oe_o(kick_oe), .nonmaskable_irq_n_o(nmi_n),
    .mcu_reset_n_o(rst_n), .drain_supply_enable_out_o(supply), .rf_path_switch_o(rf),
    .multidrop_driver_enable_o(md_en), .front_port_driver_enable_o(fp_en), .multidrop_tx_o(md_tx),
    .front_tx_o(fp_tx), .mcu_rx_o(mcu_rx), .addr_match_o(match), .mux_select_o(mux));
  supervisor_model #(.STALL(3 * KC)) supervisor_model_inst (
    .clk_i(clk), .nrst_i(nrst), .kick_i(kick), .kick_oe_i(kick_oe), .nmi_n_o(sup_nmi_n), .reset_n_o(sup_rst_n));
  // ---------------------------
  // helpers
  // ---------------------------
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  task chk(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task poke(input int k);
    case (k)
      0: keep = ~keep;
      1: bus_en = ~bus_en;
      default: md_rx = ~md_rx;
    endcase
    step(1);
  endtask : poke
  task wait_kick;
    logic k0;
    int n;
    k0 = kick;
    n = 0;
    while (kick === k0 && n < 2 * KC + 4) begin
      step(1);
      n++;
    end
    gap = n;
    chk(kick !== k0, 1'b1, "kick did not toggle");
    if (kick === k0) begin
      end_of_test();
    end
  endtask : wait_kick
  // ---------------------------
  // scenarios
  // ---------------------------
  task t_after_reset;
    chk(md_en, 1'b1, "multidrop not enabled");
    chk(fp_en, 1'b0, "front port enabled");
    chk(supply, 1'b0, "supply on after reset");
    chk(kick_oe, 1'b1, "kick not driven");
  endtask : t_after_reset
  task t_supply;
    req = 1'b1;
    step(1);
    chk(supply, 1'b1, "supply not granted");
    for (int c = 0; c < 3; c++) begin
      stby = (c == 0);
      gate_ok = (c != 1);
      unsafe = (c == 2);
      step(1);
      chk(supply, 1'b0, "supply on while unsafe");
      stby = 1'b0;
      gate_ok = 1'b1;
      unsafe = 1'b0;
      step(1);
      chk(supply, 1'b1, "supply not restored");
    end
    req = 1'b0;
    step(1);
    chk(supply, 1'b0, "supply on without request");
  endtask : t_supply
  task t_rf;
    ce = 1'b0;
    xmit = 1'b1;
    step(2);
    chk(rf, 1'b0, "rf moved while frozen");
    ce = 1'b1;
    step(1);
    chk(rf, 1'b1, "rf not through in transmit");
    xmit = 1'b0;
    step(1);
    chk(rf, 1'b0, "rf not terminated");
  endtask : t_rf
  task t_ports;
    sel_n = 1'b0;
    fr_rx = 1'b1;
    tx = 1'b1;
    step(1);
    chk(fp_en & ~md_en, 1'b1, "front select ignored");
    chk(mcu_rx, 1'b1, "rx not from front port");
    chk(md_tx & fp_tx, 1'b1, "tx not on both ports");
    sel_n = 1'b1;
    tx = 1'b0;
    step(1);
    chk(md_en & ~fp_en, 1'b1, "multidrop not restored");
    chk(mcu_rx | md_tx | fp_tx, 1'b0, "rx or tx path wrong");
  endtask : t_ports
  task t_addr;
    fvalid = 1'b1;
    faddr = 8'h5a;
    step(1);
    faddr = 8'ha5;
    chk(match, 1'b1, "own address missed");
    step(1);
    fvalid = 1'b0;
    faddr = 8'h5a;
    chk(match, 1'b0, "foreign address accepted");
    step(1);
    chk(match, 1'b0, "match without a strobe");
  endtask : t_addr
  task t_mux;
    mload = 1'b1;
    mstep = 1'b1;
    mval = 3'h7;
    step(1);
    mload = 1'b0;
    chk(mux === 3'h7, 1'b1, "load lost to step");
    for (int i = 0; i < 8; i++) begin
      step(1);
      chk(mux === 3'(i), 1'b1, "channel step wrong");
    end
    mstep = 1'b0;
  endtask : t_mux
  task t_watchdog;
    logic k0;
    int n;
    for (int k = 0; k < 3; k++) begin
      poke(k);
      wait_kick();
      if (k > 0) begin
        chk(gap == KC - 1, 1'b1, "kick interval wrong");
      end
    end
    step(2);
    chk(nmi_n & rst_n, 1'b1, "mcu lines not high");
    k0 = kick;
    step(2 * KC);
    chk(kick, k0, "kick toggled while idle");
    n = 0;
    while (nmi_n !== 1'b0 && n < 2 * KC) begin
      step(1);
      n++;
    end
    chk(nmi_n, 1'b0, "stall not passed on");
    if (nmi_n !== 1'b0) begin
      end_of_test();
    end
    poke(0);
    wait_kick();
    step(2);
    chk(nmi_n, 1'b1, "nmi not released");
  endtask : t_watchdog
  task t_jumper;
    logic k0;
    jmp = 1'b0;
    step(1);
    chk(kick_oe, 1'b0, "kick driven without jumper");
    k0 = kick;
    poke(1);
    step(2 * KC + 4);
    chk(kick, k0, "kick toggled without jumper");
    jmp = 1'b1;
    poke(2);
    wait_kick();
  endtask : t_jumper
  initial begin
    step(20);
    nrst = 1'b1;
    step(3);
    t_after_reset();
    t_supply();
    t_rf();
    t_ports();
    t_addr();
    t_mux();
    t_watchdog();
    t_jumper();
    end_of_test();
  end
endmodule : segment_glue_tb_top

/* File: supervisor_model.sv */
// supervisor_model: behavioural external watchdog supervisor
// assumes kick line pulled low while undriven, one board clock
`timescale 1ns/1ps
module supervisor_model #(
  parameter int STALL = 192
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic kick_i,
  input wire logic kick_oe_i,
  output logic nmi_n_o,
  output logic reset_n_o
);
  // ---------------------------
  // stall timer
  // ---------------------------
  logic line;
  logic last;
  int idle;
  assign line = kick_oe_i ? kick_i : 1'b0;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last <= 1'b0;
      idle <= 0;
    end else begin
      last <= line;
      idle <= (line !== last) ? 0 : ((idle < STALL) ? idle + 1 : idle);
    end
  end
  assign nmi_n_o = (idle < STALL);
  assign reset_n_o = 1'b1;
endmodule : supervisor_model
